// >>> common/mpw_pkg.sv
// Package of constants and types for the match based PWM unit
// Functional notes
// RL1 - Period match restarts count, new cycle begins
// RL2 - Single-edge outputs rise at period match
// RL3 - Own match register sets falling edge
// RL4 - Double-edge: rise and fall match registers
// RL5 - Seven match registers, six outputs
// RL6 - Match may continue, stop, reset, interrupt
// RL7 - Count peripheral clock or capture input edges
// RL8 - Any period/width; shared repetition rate
// RL9 - Released match values load at cycle start
// RL10 - PWM disabled: plain timer, outputs inactive
// RL11 - 32-bit counter with 32-bit prescaler
// RL12 - Master and slave units start together
// RL13 - Prescaler wraps at limit, counter increments
`default_nettype none
package mpw_pkg;

    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT = 6;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PC = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_MCR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_OCR = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_REL = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_MR0 = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_MR_LAST = 8'h58;

    // Match control: three bits per match register
    localparam int MCR_W = 3;
    localparam int MCR_INT = 0;
    localparam int MCR_RST = 1;
    localparam int MCR_STOP = 2;

    // Output control fields
    localparam int OCR_DBL_LSB = 0;
    localparam int OCR_OE_LSB = 8;
    localparam logic [31:0] OCR_MASK = 32'h00003f3e;
    localparam logic [31:0] MCR_MASK = 32'h001fffff;

    localparam logic [31:0] RST_WORD = 32'h00000000;

    typedef enum logic [1:0] {
        MPW_MODE_TIMER = 2'b00,
        MPW_MODE_RISE = 2'b01,
        MPW_MODE_FALL = 2'b10,
        MPW_MODE_BOTH = 2'b11
    } mpw_mode_t;

    typedef struct packed {
        logic [24:0] rsvd;
        logic slave;
        logic cap_sel;
        mpw_mode_t mode;
        logic pwm_en;
        logic cnt_rst;
        logic cnt_en;
    } mpw_ctrl_t;

endpackage : mpw_pkg
`default_nettype wire

// >>> logic/mpw_match_pwm.sv
// Match based PWM unit with APB register slave
`timescale 1ns/1ps
`default_nettype none
module mpw_match_pwm
    import mpw_pkg::*;
#(
    parameter int NUM_CAP = 2
) (
    input wire logic pclk, // APB clock, 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [NUM_CAP-1:0] cap_in, // Capture pins, asynchronous
    input wire logic lockstep_in, // Run gate from master unit
    output logic lockstep_out, // Run level to slave unit
    output logic [NUM_OUT-1:0] pwm_out, // PWM outputs 1..6
    output logic [NUM_OUT-1:0] pwm_oe, // PWM output enables
    output logic irq // Level interrupt
);

    generate
        if (NUM_CAP < 1 || NUM_CAP > 2) begin : g_bad_cap
            $error("NUM_CAP must be 1 or 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Decoding

    function automatic logic is_mr_addr(input logic [ADDR_W-1:0] a);
        is_mr_addr = (a >= OFF_MR0) && (a <= OFF_MR_LAST) && (a[1:0] == 2'b00);
    endfunction : is_mr_addr

    function automatic logic [2:0] mr_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFF_MR0;
        mr_index = d[4:2];
    endfunction : mr_index

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a == OFF_CTRL) || (a == OFF_TC) || (a == OFF_PR) || (a == OFF_PC) ||
                  (a == OFF_MCR) || (a == OFF_OCR) || (a == OFF_REL) ||
                  (a == OFF_INT_STAT) || (a == OFF_INT_MASK) || is_mr_addr(a);
    endfunction : addr_ok

    ////////////////////////////////////////////////////////////////////////
    // State

    mpw_ctrl_t ctrl;
    mpw_ctrl_t next_ctrl;
    logic [31:0] tc;
    logic [31:0] pr;
    logic [31:0] pc;
    logic [31:0] mcr;
    logic [31:0] ocr;
    logic [NUM_MATCH-1:0] rel;
    logic [NUM_MATCH-1:0] int_stat;
    logic [NUM_MATCH-1:0] next_int_stat;
    logic [NUM_MATCH-1:0] int_mask;
    logic [31:0] mr [NUM_MATCH];
    logic [31:0] act_mr [NUM_MATCH];
    logic [31:0] next_act [NUM_MATCH];
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] mcr_int;
    logic [NUM_MATCH-1:0] mcr_rst;
    logic [NUM_MATCH-1:0] mcr_stop;
    logic [NUM_CAP-1:0] cap_s1;
    logic [NUM_CAP-1:0] cap_s2;
    logic [NUM_CAP-1:0] cap_s3;
    logic [NUM_CAP-1:0] cap_lvl;
    logic [NUM_CAP-1:0] cap_rise;
    logic [NUM_CAP-1:0] cap_fall;
    logic tick;
    logic run;
    logic inc;
    logic do_reset;
    logic do_stop;
    logic wr;
    logic setup;
    logic [2:0] widx;

    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;
    assign widx = mr_index(paddr);

    ////////////////////////////////////////////////////////////////////////
    // Capture pin conditioning

    // Edge counts only once the second and third stage agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_s1 <= '0;
            cap_s2 <= '0;
            cap_s3 <= '0;
            cap_lvl <= '0;
            cap_rise <= '0;
            cap_fall <= '0;
        end else begin
            cap_s1 <= cap_in;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
            for (int i = 0; i < NUM_CAP; i++) begin
                cap_rise[i] <= 1'b0;
                cap_fall[i] <= 1'b0;
                if (cap_s2[i] == cap_s3[i]) begin
                    cap_lvl[i] <= cap_s3[i];
                    cap_rise[i] <= cap_s3[i] && !cap_lvl[i];
                    cap_fall[i] <= !cap_s3[i] && cap_lvl[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count source, prescaler and counter

    logic sel_rise;
    logic sel_fall;
    assign sel_rise = (NUM_CAP > 1) ? cap_rise[NUM_CAP-1] && ctrl.cap_sel || cap_rise[0] && !ctrl.cap_sel
                                    : cap_rise[0];
    assign sel_fall = (NUM_CAP > 1) ? cap_fall[NUM_CAP-1] && ctrl.cap_sel || cap_fall[0] && !ctrl.cap_sel
                                    : cap_fall[0];

    always_comb begin
        case (ctrl.mode)
            MPW_MODE_TIMER: tick = 1'b1; // [RL7]
            MPW_MODE_RISE: tick = sel_rise; // [RL7]
            MPW_MODE_FALL: tick = sel_fall;
            MPW_MODE_BOTH: tick = sel_rise || sel_fall;
            default: tick = 1'b0;
        endcase
    end

    // Slave counts only while the master's run level is high
    assign run = ctrl.cnt_en && !ctrl.cnt_rst && (!ctrl.slave || lockstep_in); // [RL12]
    assign inc = run && tick && (pc == pr); // [RL13]

    generate
        for (genvar g = 0; g < NUM_MATCH; g++) begin : g_match
            assign mcr_int[g] = mcr[g*MCR_W+MCR_INT];
            assign mcr_rst[g] = mcr[g*MCR_W+MCR_RST];
            assign mcr_stop[g] = mcr[g*MCR_W+MCR_STOP];
            assign hit[g] = inc && (tc == act_mr[g]); // [RL5]
            assign next_act[g] = (ctrl.pwm_en && hit[0] && rel[g]) ? mr[g] : act_mr[g];
        end
    endgenerate

    // Period match always restarts the count in PWM mode
    assign do_reset = |(hit & mcr_rst) || (ctrl.pwm_en && hit[0]); // [RL6] [RL1]
    assign do_stop = |(hit & mcr_stop); // [RL6]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= RST_WORD;
        end else if (ctrl.cnt_rst) begin
            pc <= RST_WORD;
        end else if (run && tick) begin
            pc <= (pc == pr) ? RST_WORD : pc + 32'h1; // [RL13] [RL11]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc <= RST_WORD;
        end else if (ctrl.cnt_rst) begin
            tc <= RST_WORD;
        end else if (inc) begin
            tc <= do_reset ? RST_WORD : tc + 32'h1; // [RL11] [RL8] [RL6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register, with stop on match

    always_comb begin
        next_ctrl = ctrl;
        if (wr && paddr == OFF_CTRL) begin
            next_ctrl = mpw_ctrl_t'(pwdata);
            next_ctrl.rsvd = '0;
        end
        if (do_stop) begin
            next_ctrl.cnt_en = 1'b0; // [RL6]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= mpw_ctrl_t'(RST_WORD);
            lockstep_out <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            // Same edge as own enable, so a slave starts in step
            lockstep_out <= next_ctrl.cnt_en && !next_ctrl.cnt_rst; // [RL12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pr <= RST_WORD;
            mcr <= RST_WORD;
            ocr <= RST_WORD;
            int_mask <= '0;
        end else if (wr) begin
            if (paddr == OFF_PR) pr <= pwdata;
            if (paddr == OFF_MCR) mcr <= pwdata & MCR_MASK;
            if (paddr == OFF_OCR) ocr <= pwdata & OCR_MASK;
            if (paddr == OFF_INT_MASK) int_mask <= pwdata[NUM_MATCH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match registers: shadow, release and active copy

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_MATCH; i++) mr[i] <= RST_WORD;
        end else if (wr && is_mr_addr(paddr)) begin
            mr[widx] <= pwdata;
        end
    end

    // Release flags clear at cycle start; a new release wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rel <= '0;
        end else begin
            rel <= (rel & ~((ctrl.pwm_en && hit[0]) ? rel : '0)) |
                   ((wr && paddr == OFF_REL) ? pwdata[NUM_MATCH-1:0] : '0); // [RL9]
        end
    end

    // Outside PWM mode writes act at once, as in a plain timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_MATCH; i++) act_mr[i] <= RST_WORD;
        end else begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                act_mr[i] <= ctrl.pwm_en ? next_act[i] : mr[i]; // [RL9] [RL10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM outputs

    generate
        for (genvar k = 1; k <= NUM_OUT; k++) begin : g_out
            logic dbl;
            assign dbl = (k >= 2) && ocr[OCR_DBL_LSB+k-1];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pwm_out[k-1] <= 1'b0;
                    pwm_oe[k-1] <= 1'b0;
                end else begin
                    pwm_oe[k-1] <= ctrl.pwm_en && ocr[OCR_OE_LSB+k-1]; // [RL10]
                    if (!ctrl.pwm_en) begin
                        pwm_out[k-1] <= 1'b0; // [RL10]
                    end else if (dbl) begin
                        if (hit[k]) begin
                            pwm_out[k-1] <= 1'b0; // [RL4]
                        end else if (hit[k-1]) begin
                            pwm_out[k-1] <= 1'b1; // [RL4]
                        end
                    end else begin
                        // Zero falling match means constant low
                        if (hit[0]) begin
                            pwm_out[k-1] <= (next_act[k] != 32'h0); // [RL2] [RL8]
                        end else if (hit[k]) begin
                            pwm_out[k-1] <= 1'b0; // [RL3]
                        end
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Hardware set wins over a same-cycle write-one clear
    always_comb begin
        next_int_stat = int_stat;
        if (wr && paddr == OFF_INT_STAT) begin
            next_int_stat = int_stat & ~pwdata[NUM_MATCH-1:0];
        end
        next_int_stat = next_int_stat | (hit & mcr_int); // [RL6]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= '0;
            irq <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            irq <= |(next_int_stat & int_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, data latched in setup

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        if (is_mr_addr(paddr)) begin
            rdata = mr[widx];
        end else begin
            case (paddr)
                OFF_CTRL: rdata = 32'(ctrl);
                OFF_TC: rdata = tc;
                OFF_PR: rdata = pr;
                OFF_PC: rdata = pc;
                OFF_MCR: rdata = mcr;
                OFF_OCR: rdata = ocr;
                OFF_REL: rdata = 32'(rel);
                OFF_INT_STAT: rdata = 32'(int_stat);
                OFF_INT_MASK: rdata = 32'(int_mask);
                default: rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= !addr_ok(paddr);
                prdata <= pwrite ? 32'h0 : rdata;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule : mpw_match_pwm
`default_nettype wire

// >>> bench/mpw_match_pwm_monitor.sv
// Checker for bus handshake and output timing of the PWM unit
`timescale 1ns/1ps
`default_nettype none
module mpw_match_pwm_monitor
    import mpw_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic lockstep_out, // Run level
    input wire logic [NUM_OUT-1:0] pwm_out, // Outputs
    input wire logic [NUM_OUT-1:0] pwm_oe, // Enables
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr_done;
    assign wr_done = psel && penable && pwrite && pready;
    ////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready ##1 !pready;
    endsequence
    a_setup_answer: assert property (s_setup |=> s_answer)
        else $error("no single ready after setup");
    a_no_early_ready: assert property (s_setup |-> !pready)
        else $error("ready during setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_error_zero_data: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("bad error answer");
    a_quiet_after_reset: assert property ($rose(presetn) |-> pwm_out == 6'h00 && !irq)
        else $error("outputs active after reset");
    // Enables only move through register writes, never from counting
    // Enable follows the written control word one edge late
    a_oe_by_write: assert property ($changed(pwm_oe) |-> $past(wr_done, 2))
        else $error("enable moved without write");
    a_run_by_write: assert property ($rose(lockstep_out) |-> $past(wr_done))
        else $error("run level rose without write");
    a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_done))
        else $error("interrupt fell without write");
endmodule : mpw_match_pwm_monitor
`default_nettype wire

// >>> bench/mpw_load_model.sv
// Load model timing the pulses seen on each PWM pin
`timescale 1ns/1ps
`default_nettype none
module mpw_load_model
    import mpw_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic [NUM_OUT-1:0] pwm_out, // Pin data
    input wire logic [NUM_OUT-1:0] pwm_oe, // Pin enables
    output int hi_w [NUM_OUT], // Last high width
    output int per [NUM_OUT] // Last rise to rise span
);
    int hc [NUM_OUT];
    int pc [NUM_OUT];
    logic [NUM_OUT-1:0] prev = 6'h00;
    logic [NUM_OUT-1:0] pin;
    // Pins carry pull-downs, so an undriven pin reads low
    assign pin = pwm_out & pwm_oe;
    always @(posedge pclk) begin
        prev <= pin;
        for (int k = 0; k < NUM_OUT; k++) begin
            pc[k] <= (pin[k] && !prev[k]) ? 1 : pc[k] + 1;
            hc[k] <= pin[k] ? hc[k] + 1 : 0;
            if (pin[k] && !prev[k]) begin
                per[k] <= pc[k];
            end
            if (!pin[k] && prev[k]) begin
                hi_w[k] <= hc[k];
            end
        end
    end
endmodule : mpw_load_model
`default_nettype wire

// >>> bench/mpw_match_pwm_tb.sv
// Self-checking bench for the match based PWM unit
`timescale 1ns/1ps
`default_nettype none
module mpw_match_pwm_tb;
    import mpw_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, lock_in, lock_out, irq, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cap;
    logic [NUM_OUT-1:0] pwm_out, pwm_oe;
    int hi_w [NUM_OUT];
    int per [NUM_OUT];
    int mr [6] = '{9, 5, 2, 6, 7, 2};
    logic [ADDR_W-1:0] offs [6] = '{OFF_CTRL, OFF_PR, OFF_MCR, OFF_OCR, OFF_INT_MASK, OFF_MR0};
    int n_errors = 0;
    int total_checks = 0;

    mpw_match_pwm DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cap_in(cap), .lockstep_in(lock_in), .lockstep_out(lock_out),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
    mpw_load_model LOAD (.pclk(pclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .hi_w(hi_w), .per(per));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Starts on a fresh edge so back-to-back calls never drive psel twice at once
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rchk(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        chk(n, e, rd);
    endtask : rchk

    task automatic wrap_up();
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        cap = 2'b00;
        lock_in = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) rchk("reset", offs[i], 32'h00000000);
        rchk("unmapped", 8'h30, 32'h00000000);
        chk("slverr", 32'h1, 32'(err));
        foreach (mr[i]) wr(OFF_MR0 + 8'(4 * i), 32'(mr[i]));
        wr(OFF_MCR, 32'h00000001);
        wr(OFF_OCR, 32'h00003f14);
        wr(OFF_CTRL, 32'h00000005);
        repeat (40) @(posedge pclk);
        chk("period", 32'd10, per[0]);
        chk("share", 32'd10, per[2]);
        chk("single", 32'd3, hi_w[0] - hi_w[1]);
        chk("pos pulse", 32'd4, hi_w[2]);
        chk("neg pulse", 32'd5, hi_w[4]);
        chk("const low", 32'd0, hi_w[5]);
        chk("const low pin", 32'h0, 32'(pwm_out[5]));
        chk("masked", 32'h0, 32'(irq));
        rchk("status", OFF_INT_STAT, 32'h00000001);
        wr(OFF_INT_MASK, 32'h00000001);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, 32'(irq));
        wr(OFF_MR0 + 8'h04, 32'd7);
        repeat (30) @(posedge pclk);
        chk("unreleased", 32'd3, hi_w[0] - hi_w[1]);
        wr(OFF_REL, 32'h00000002);
        repeat (30) @(posedge pclk);
        chk("released", 32'd5, hi_w[0] - hi_w[1]);
        wr(OFF_PR, 32'd2);
        repeat (80) @(posedge pclk);
        chk("prescale", 32'd30, per[0]);
        wr(OFF_MCR, 32'h00000021);
        repeat (60) @(posedge pclk);
        rchk("stopped", OFF_CTRL, 32'h00000004);
        chk("run level", 32'h0, 32'(lock_out));
        wr(OFF_INT_STAT, 32'h00000001);
        repeat (2) @(posedge pclk);
        chk("irq clear", 32'h0, 32'(irq));
        wr(OFF_MCR, 32'h00000002);
        wr(OFF_CTRL, 32'h00000001);
        repeat (100) @(posedge pclk);
        chk("pins off", 32'h0, 32'({pwm_out, pwm_oe}));
        chk("run on", 32'h1, 32'(lock_out));
        xfer(1'b0, OFF_TC, 32'h00000000);
        chk("wrap", 32'h1, 32'(rd <= 32'd9));
        wr(OFF_PR, 32'd0);
        wr(OFF_MCR, 32'h00000000);
        // Modes rise, fall and both, three pulses each
        for (int m = 1; m < 4; m++) begin
            wr(OFF_CTRL, 32'h00000002);
            // Fall mode counts the second capture pin
            wr(OFF_CTRL, 32'(1 + 8 * m + ((m == 2) ? 32 : 0)));
            repeat (3) begin
                cap <= (m == 2) ? 2'b10 : 2'b01;
                repeat (6) @(posedge pclk);
                cap <= 2'b00;
                repeat (6) @(posedge pclk);
            end
            rchk("edges", OFF_TC, (m == 3) ? 32'd6 : 32'd3);
        end
        // Slave unit waits for the master's run level
        wr(OFF_CTRL, 32'h00000002);
        wr(OFF_CTRL, 32'h00000041);
        repeat (10) @(posedge pclk);
        rchk("slave held", OFF_TC, 32'h00000000);
        lock_in <= 1'b1;
        repeat (10) @(posedge pclk);
        rchk("slave runs", OFF_TC, 32'd11);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
endmodule : mpw_match_pwm_tb

bind mpw_match_pwm mpw_match_pwm_monitor MON (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lockstep_out(lockstep_out), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
`default_nettype wire
